// file: core/ecpt_pkg.sv
package ecpt_pkg;

    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // Timer mode control: operating-mode field
    localparam int OP_MODE_LSB = 2;
    // Prescale/edge config: count clock select and edge select fields
    localparam int CLK_SEL_LSB = 0;
    localparam int EDGE_SEL_LSB = 4;
    // Output control register bits
    localparam int OUT_EN_BIT = 0;
    localparam int TOGGLE_BIT = 1;
    localparam int ONESHOT_EN_BIT = 2;
    localparam int EXT_TRIG_BIT = 3;
    localparam int SOFT_TRIG_BIT = 6;
    // Capture/compare control: compare one used as capture register
    localparam int CAP_ONE_BIT = 0;

    // Internal count clock = system clock / 2^exponent
    localparam int PRE_W = 7;
    localparam logic [2:0] PRE_EXP0 = 3'h2;
    localparam logic [2:0] PRE_EXP1 = 3'h3;
    localparam logic [2:0] PRE_EXP2 = 3'h5;
    // Clock select code that counts external events instead
    localparam logic [1:0] CLK_SEL_EXT = 2'h3;

    typedef enum logic [1:0] {
        ECPT_STOP = 2'b00,
        ECPT_FREE = 2'b01,
        ECPT_EDGECLR = 2'b10,
        ECPT_MATCHCLR = 2'b11
    } ecpt_mode_t;

    typedef enum logic [1:0] {
        ECPT_FALL = 2'b00,
        ECPT_RISE = 2'b01,
        ECPT_NONE = 2'b10,
        ECPT_BOTH = 2'b11
    } ecpt_edge_t;

    typedef struct packed {
        logic matchZero;
        logic captureOne;
    } ecpt_irq_t;

endpackage

// file: core/ecpt_prescale.sv
module ecpt_prescale #(
    parameter int PW = ecpt_pkg::PRE_W
) (
    input wire logic clk_sys, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic [1:0] clkSel, // Count clock select
    output logic tick // One-cycle count clock enable
);
    import ecpt_pkg::*;

    typedef struct packed {
        logic [PW-1:0] div;
        logic tick;
    } ecpt_pre_t;

    ecpt_pre_t st_ff;
    ecpt_pre_t nxt_st;
    logic [PW-1:0] mask;

    always_comb
    begin
        unique case (clkSel)
            2'h0: mask = PW'((1 << PRE_EXP0) - 1);
            2'h1: mask = PW'((1 << PRE_EXP1) - 1);
            2'h2: mask = PW'((1 << PRE_EXP2) - 1);
            // External events count; the input filter samples at the fastest rate
            2'h3: mask = PW'((1 << PRE_EXP0) - 1);
        endcase
        nxt_st.div = st_ff.div + PW'(1);
        nxt_st.tick = (st_ff.div & mask) == mask;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tick = st_ff.tick;

endmodule

// file: core/ecpt_edge_filter.sv
module ecpt_edge_filter (
    input wire logic clk_sys, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic pinIn, // Raw external pin
    input wire logic sampleEn, // Sampling enable
    input wire ecpt_pkg::ecpt_edge_t edgeSel, // Valid edge selection
    output logic validEdge // One-cycle pulse per accepted edge
);
    import ecpt_pkg::*;

    typedef struct packed {
        logic sync0;
        logic sync1;
        logic prevSample;
        logic level;
        logic edgeHit;
    } ecpt_flt_t;

    ecpt_flt_t st_ff;
    ecpt_flt_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.sync0 = pinIn;
        nxt_st.sync1 = st_ff.sync0;
        nxt_st.edgeHit = 1'b0;
        if (sampleEn)
        begin
            nxt_st.prevSample = st_ff.sync1;
            if (st_ff.sync1 == st_ff.prevSample && st_ff.sync1 != st_ff.level)
            begin
                nxt_st.level = st_ff.sync1;
                unique case (edgeSel)
                    ECPT_FALL: nxt_st.edgeHit = !st_ff.sync1;
                    ECPT_RISE: nxt_st.edgeHit = st_ff.sync1;
                    ECPT_NONE: nxt_st.edgeHit = 1'b0;
                    ECPT_BOTH: nxt_st.edgeHit = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign validEdge = st_ff.edgeHit;

endmodule

// file: core/ecpt_timer.sv
module ecpt_timer (
    input wire logic clk_sys, // 100 MHz system clock
    input wire logic nrst, // Async reset, active low
    input wire logic [7:0] timerModeCtrl, // Timer mode control register
    input wire logic [7:0] prescaleEdgeConfig, // Count clock and edge select
    input wire logic [7:0] captureCompareControl, // Capture/compare control
    input wire logic [7:0] outputControlReg, // Output control register
    input wire logic outCtrlWr, // Write strobe of output control register
    input wire logic [15:0] compareRegZero, // Compare register zero
    input wire logic [15:0] compareRegOne, // Compare register one value
    input wire logic captureReadStb, // Read strobe of captured value
    input wire logic overflowClear, // Clears the overflow flag
    input wire logic externalEventInput, // External event / trigger pin
    output logic [15:0] countRegister, // Current count
    output logic [15:0] captureValue, // Value captured on valid edge
    output logic [15:0] captureReadData, // Data returned by a capture read
    output logic pulseOutputPin, // Square wave / one-shot output
    output ecpt_pkg::ecpt_irq_t irq, // Interrupt request pulses
    output logic overflowFlag // Sticky overflow flag
);
    import ecpt_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] capVal;
        logic [CNT_W-1:0] rdData;
        logic busy;
        logic outLvl;
        logic ovf;
        ecpt_irq_t irq;
    } ecpt_state_t;

    ecpt_state_t st_ff;
    ecpt_state_t nxt_st;

    ecpt_mode_t opMode;
    ecpt_edge_t edgeSel;
    logic [1:0] clkSel;
    logic preTick;
    logic validEdge;
    logic running;
    logic extSrc;
    logic tick;
    logic outEn;
    logic toggleEn;
    logic oneShotEn;
    logic extTrigEn;
    logic capEn;
    logic cntMatchZero;
    logic cntMatchOne;
    logic softTrig;
    logic extTrig;
    logic startPulse;
    logic ovfSet;

    assign opMode = ecpt_mode_t'(timerModeCtrl[OP_MODE_LSB +: 2]);
    assign edgeSel = ecpt_edge_t'(prescaleEdgeConfig[EDGE_SEL_LSB +: 2]);
    assign clkSel = prescaleEdgeConfig[CLK_SEL_LSB +: 2];
    assign outEn = outputControlReg[OUT_EN_BIT];
    assign toggleEn = outputControlReg[TOGGLE_BIT];
    assign oneShotEn = outputControlReg[ONESHOT_EN_BIT];
    assign extTrigEn = outputControlReg[EXT_TRIG_BIT];
    assign capEn = captureCompareControl[CAP_ONE_BIT];

    // free prescaler
    // The divider is never restarted with the counter, so the first count
    // clock after a start lands anywhere within one period.
    ecpt_prescale u_prescale (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clkSel(clkSel),
        .tick(preTick)
    );

    ecpt_edge_filter u_edge (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pinIn(externalEventInput),
        .sampleEn(preTick),
        .edgeSel(edgeSel),
        .validEdge(validEdge)
    );

    assign running = opMode != ECPT_STOP;
    assign extSrc = clkSel == CLK_SEL_EXT;
    assign tick = extSrc ? validEdge : preTick;

    assign cntMatchZero = st_ff.cnt == compareRegZero;
    assign cntMatchOne = st_ff.cnt == compareRegOne;

    assign softTrig = outCtrlWr && outputControlReg[SOFT_TRIG_BIT] && oneShotEn;
    assign extTrig = oneShotEn && extTrigEn && validEdge && !st_ff.busy;
    assign startPulse = running && (softTrig || extTrig);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.irq = '0;
        ovfSet = 1'b0;
        if (!running)
        begin
            nxt_st.cnt = CNT_RST;
            nxt_st.busy = 1'b0;
            nxt_st.outLvl = 1'b0;
        end
        else if (startPulse)
        begin
            nxt_st.cnt = CNT_RST;
            nxt_st.busy = 1'b1;
            nxt_st.outLvl = 1'b0;
        end
        else
        begin
            if (opMode == ECPT_EDGECLR && validEdge && !oneShotEn)
                nxt_st.cnt = CNT_RST;
            else if (tick)
            begin
                if (cntMatchZero && opMode == ECPT_MATCHCLR)
                    nxt_st.cnt = CNT_RST;
                else
                begin
                    nxt_st.cnt = st_ff.cnt + CNT_ONE;
                    ovfSet = st_ff.cnt == CNT_MAX;
                end
            end
            if (tick && cntMatchZero)
                nxt_st.irq.matchZero = 1'b1;
            if (tick && cntMatchZero && toggleEn && !oneShotEn)
                nxt_st.outLvl = !st_ff.outLvl;
            if (st_ff.busy && tick)
            begin
                if (cntMatchZero)
                begin
                    nxt_st.outLvl = 1'b0;
                    nxt_st.busy = 1'b0;
                end
                else if (cntMatchOne)
                    nxt_st.outLvl = 1'b1;
            end
        end
        if (!outEn)
            nxt_st.outLvl = 1'b0;
        // A set in the same cycle as a clear is kept
        nxt_st.ovf = (st_ff.ovf && !overflowClear) || ovfSet;
        if (captureReadStb)
            nxt_st.rdData = st_ff.capVal;
        if (capEn && validEdge && running)
        begin
            nxt_st.capVal = st_ff.cnt;
            nxt_st.irq.captureOne = 1'b1;
            if (captureReadStb)
                nxt_st.rdData = st_ff.cnt;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign countRegister = st_ff.cnt;
    assign captureValue = st_ff.capVal;
    assign captureReadData = st_ff.rdData;
    assign pulseOutputPin = st_ff.outLvl;
    assign irq = st_ff.irq;
    assign overflowFlag = st_ff.ovf;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    stop_clears_a: assert property (
        !running |=> countRegister == CNT_RST && !pulseOutputPin)
        else $error("count not cleared while stopped");

    match_clear_a: assert property (
        running && opMode == ECPT_MATCHCLR && tick && cntMatchZero && !startPulse
        |=> countRegister == CNT_RST && irq.matchZero)
        else $error("compare zero match did not clear and flag");

    event_inc_a: assert property (
        running && extSrc && opMode != ECPT_EDGECLR && !startPulse && validEdge
        && !(cntMatchZero && opMode == ECPT_MATCHCLR)
        |=> countRegister == $past(countRegister) + CNT_ONE)
        else $error("external edge not counted");

    hold_count_a: assert property (
        running && !tick && !startPulse && opMode != ECPT_EDGECLR
        |=> $stable(countRegister))
        else $error("count moved without a count clock");

    toggle_out_a: assert property (
        running && outEn && toggleEn && !oneShotEn && !startPulse
        && tick && cntMatchZero ##1 outEn
        |-> pulseOutputPin != $past(pulseOutputPin))
        else $error("square wave did not toggle on match");

    soft_start_a: assert property (
        running && softTrig |=> countRegister == CNT_RST ##1 st_ff.busy || irq.matchZero)
        else $error("soft trigger did not clear and start");

    pulse_on_a: assert property (
        running && outEn && st_ff.busy && tick && cntMatchOne && !cntMatchZero
        && !startPulse ##1 outEn |-> pulseOutputPin)
        else $error("one-shot did not go active at compare one");

    pulse_off_a: assert property (
        running && st_ff.busy && tick && cntMatchZero && !startPulse
        |=> !pulseOutputPin && !st_ff.busy)
        else $error("one-shot did not end at compare zero");

    ext_ignore_a: assert property (
        running && st_ff.busy && validEdge && !softTrig && !(tick && cntMatchZero)
        |=> st_ff.busy && countRegister != CNT_RST || $past(tick))
        else $error("trigger edge restarted an active pulse");

    ovf_set_a: assert property (
        running && tick && !startPulse && countRegister == CNT_MAX
        && !(cntMatchZero && opMode == ECPT_MATCHCLR) && opMode != ECPT_EDGECLR
        |=> overflowFlag && countRegister == CNT_RST)
        else $error("overflow not flagged");

    capture_a: assert property (
        running && capEn && validEdge
        |=> captureValue == $past(countRegister) && irq.captureOne)
        else $error("capture lost");

    cap_hold_a: assert property (
        !(running && capEn && validEdge) |=> $stable(captureValue))
        else $error("captured value changed without an edge");

    read_capture_a: assert property (
        running && capEn && validEdge && captureReadStb
        |=> captureReadData == $past(countRegister))
        else $error("read did not yield to capture");

    read_plain_a: assert property (
        captureReadStb && !(running && capEn && validEdge)
        |=> captureReadData == $past(captureValue))
        else $error("read did not return captured value");

    read_hold_a: assert property (
        !captureReadStb |=> $stable(captureReadData))
        else $error("read data changed without a read");

    ext_start_a: assert property (
        running && extTrig |=> countRegister == CNT_RST && st_ff.busy)
        else $error("external trigger did not clear and start");

    wrap_zero_a: assert property (
        running && tick && !startPulse && countRegister == CNT_MAX
        && opMode == ECPT_MATCHCLR && !cntMatchZero
        |=> countRegister == CNT_RST)
        else $error("count did not wrap past maximum");

    ovf_sticky_a: assert property (
        overflowFlag && !overflowClear |=> overflowFlag)
        else $error("overflow flag lost without clear");

    ovf_clear_a: assert property (
        overflowClear && !(tick && countRegister == CNT_MAX) |=> !overflowFlag)
        else $error("overflow flag not cleared");

    irq_single_a: assert property (
        irq.matchZero |=> !irq.matchZero)
        else $error("match irq longer than one cycle");

    irq_cause_a: assert property (
        !(running && tick && cntMatchZero) |=> !irq.matchZero)
        else $error("match irq without a match");

    edge_single_a: assert property (
        validEdge |=> !validEdge)
        else $error("accepted edge longer than one cycle");

    toggle_hold_a: assert property (
        running && outEn && toggleEn && !oneShotEn && !st_ff.busy && !startPulse
        && !(tick && cntMatchZero) |=> $stable(pulseOutputPin))
        else $error("square wave moved between matches");

    pin_off_a: assert property (
        !outEn |=> !pulseOutputPin)
        else $error("output driven while disabled");

    stop_idle_a: assert property (
        !running |=> !st_ff.busy)
        else $error("pulse kept busy while stopped");

    oneshot_done_c: cover property (
        st_ff.busy && pulseOutputPin ##[1:1000] !st_ff.busy);

    toggle_c: cover property (
        toggleEn && pulseOutputPin ##[1:1000] !pulseOutputPin);

    overflow_c: cover property (!overflowFlag ##1 overflowFlag);

    capture_read_c: cover property (capEn && validEdge && captureReadStb);

    trig_ignored_c: cover property (st_ff.busy && extTrigEn && validEdge);

endmodule

// file: bench/ecpt_pulse_src.sv
// External pulse source on the event pin; idle level is low between pulses
module ecpt_pulse_src (
    input wire logic clk_sys, // System clock
    output logic pinOut // Drives the external event pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pinOut = 1'b0;

    // Ends 1 ns past the edge so callers sample settled outputs
    task automatic drive(input logic lvl, input int cycles);
        @(posedge clk_sys);
        pinOut <= lvl;
        repeat (cycles - 1) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulse(input int hi, input int lo);
        drive(1'b1, hi);
        drive(1'b0, lo);
    endtask
endmodule

// file: bench/ecpt_timer_test.sv
module ecpt_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ecpt_pkg::*;

    logic clk_sys;
    logic nrst;
    logic [7:0] modeCtrl;
    logic [7:0] preCfg;
    logic [7:0] capCtrl;
    logic [7:0] outCtrl;
    logic outWr;
    logic rdStb;
    logic [15:0] cmpZero;
    logic [15:0] cmpOne;
    logic evPin;
    logic [15:0] count;
    logic [15:0] capVal;
    logic [15:0] capRd;
    logic pulsePin;
    logic ovfFlag;
    logic ovfClr;
    ecpt_irq_t irq;
    int failCount = 0;
    int checks = 0;
    int zeroIrqs = 0;
    int capIrqs = 0;
    int n;
    int c0;
    int expRise[4] = '{0, 1, 0, 1};
    int expFull[4] = '{1, 1, 0, 2};

    ecpt_timer ecpt_timer_inst (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .timerModeCtrl(modeCtrl),
        .prescaleEdgeConfig(preCfg),
        .captureCompareControl(capCtrl),
        .outputControlReg(outCtrl),
        .outCtrlWr(outWr),
        .compareRegZero(cmpZero),
        .compareRegOne(cmpOne),
        .captureReadStb(rdStb),
        .overflowClear(ovfClr),
        .externalEventInput(evPin),
        .countRegister(count),
        .captureValue(capVal),
        .captureReadData(capRd),
        .pulseOutputPin(pulsePin),
        .irq(irq),
        .overflowFlag(ovfFlag)
    );

    ecpt_pulse_src ecpt_pulse_src_inst (
        .clk_sys(clk_sys),
        .pinOut(evPin)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Interrupt pulses last one cycle, so each is counted once
    always @(posedge clk_sys)
    begin
        if (irq.matchZero === 1'b1)
            zeroIrqs++;
        if (irq.captureOne === 1'b1)
            capIrqs++;
    end

    task automatic finalReport();
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic checkInt(input string what, input int exp, input int seen);
        checks++;
        if (seen != exp)
        begin
            failCount++;
            $display("BAD %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    // Returns the cycles until the output pin reaches lvl
    task automatic waitPin(input logic lvl, output int cyc);
        cyc = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            cyc++;
        end
        while (pulsePin !== lvl && cyc < 400);
        if (pulsePin !== lvl)
        begin
            failCount++;
            $display("BAD pin wait expected %b seen %b", lvl, pulsePin);
            finalReport();
        end
    endtask

    task automatic doReset();
        @(posedge clk_sys);
        nrst <= 1'b0;
        modeCtrl <= 8'h00;
        repeat (20) @(posedge clk_sys);
        #1;
        check16("count in reset", 16'h0000, count);
        check16("pin and flag in reset", 16'h0000, {14'h0000, pulsePin, ovfFlag});
        @(posedge clk_sys);
        nrst <= 1'b1;
    endtask

    task automatic softWr();
        @(posedge clk_sys);
        outWr <= 1'b1;
        @(posedge clk_sys);
        outWr <= 1'b0;
    endtask

    // Edge selection is written while stopped; the mode starts one edge later
    task automatic setup(input logic [7:0] mode, input logic [7:0] pre, input logic [7:0] cap,
                         input logic [7:0] oc, input logic [15:0] z, input logic [15:0] o);
        @(posedge clk_sys);
        preCfg <= pre;
        capCtrl <= cap;
        outCtrl <= oc;
        cmpZero <= z;
        cmpOne <= o;
        @(posedge clk_sys);
        modeCtrl <= mode;
        softWr();
    endtask

    initial
    begin
        nrst = 1'b0;
        modeCtrl = 8'h00;
        preCfg = 8'h00;
        capCtrl = 8'h00;
        outCtrl = 8'h00;
        outWr = 1'b0;
        rdStb = 1'b0;
        ovfClr = 1'b0;
        cmpZero = 16'h0010;
        cmpOne = 16'h0008;
        for (int e = 0; e < 4; e++)
        begin
            doReset();
            setup(8'h0c, {2'b00, 2'(e), 4'h3}, 8'h00, 8'h00, 16'h0010, 16'h0008);
            ecpt_pulse_src_inst.drive(1'b1, 30);
            check16("events after rise", 16'(expRise[e]), count);
            ecpt_pulse_src_inst.drive(1'b0, 30);
            check16("events after pulse", 16'(expFull[e]), count);
        end
        doReset();
        setup(8'h0c, 8'h13, 8'h00, 8'h00, 16'h0003, 16'h0001);
        ecpt_pulse_src_inst.pulse(2, 30);
        check16("count after glitch", 16'h0000, count);
        c0 = zeroIrqs;
        repeat (3) ecpt_pulse_src_inst.pulse(30, 30);
        check16("count at compare", 16'h0003, count);
        ecpt_pulse_src_inst.pulse(30, 30);
        check16("count after match", 16'h0000, count);
        checkInt("match irqs", c0 + 1, zeroIrqs);
        for (int c = 4; c < 10; c += 5)
        begin
            doReset();
            setup(8'h0c, 8'h10, 8'h00, 8'h03, 16'(c), 16'h0001);
            waitPin(1'b1, n);
            waitPin(1'b0, n);
            checkInt("half period", (c + 1) * 4, n);
        end
        doReset();
        setup(8'h04, 8'h10, 8'h00, 8'h45, 16'h0005, 16'h0002);
        for (int k = 0; k < 2; k++)
        begin
            c0 = zeroIrqs;
            waitPin(1'b1, n);
            waitPin(1'b0, n);
            checkInt("one-shot width", 12, n);
            repeat (2) @(posedge clk_sys);
            checkInt("end irq", c0 + 1, zeroIrqs);
            repeat (40) @(posedge clk_sys);
            #1;
            check16("runs on", 16'h0001, {15'h0000, count > 16'h0005});
            softWr();
        end
        @(posedge clk_sys);
        modeCtrl <= 8'h00;
        repeat (3) @(posedge clk_sys);
        #1;
        repeat (20) @(posedge clk_sys);
        #1;
        check16("stopped count", CNT_RST, count);
        check16("stopped pin", 16'h0000, {15'h0000, pulsePin});
        @(posedge clk_sys);
        ovfClr <= 1'b1;
        @(posedge clk_sys);
        ovfClr <= 1'b0;
        #1;
        check16("flag after clear", 16'h0000, {15'h0000, ovfFlag});
        doReset();
        setup(8'h04, 8'h10, 8'h00, 8'h0d, 16'h0014, 16'h0002);
        fork
            begin
                waitPin(1'b1, n);
                waitPin(1'b0, n);
            end
            begin
                ecpt_pulse_src_inst.pulse(40, 10);
                ecpt_pulse_src_inst.pulse(30, 10);
            end
        join
        checkInt("triggered width", 72, n);
        doReset();
        setup(8'h08, 8'h11, 8'h00, 8'h00, 16'hffff, 16'hfffe);
        repeat (100) @(posedge clk_sys);
        #1;
        check16("edge-clear runs", 16'h0001, {15'h0000, count > 16'h0003});
        ecpt_pulse_src_inst.drive(1'b1, 20);
        check16("edge-clear count", 16'h0001, {15'h0000, count <= 16'h0003});
        doReset();
        setup(8'h04, 8'h10, 8'h01, 8'h00, 16'hffff, 16'hfffe);
        c0 = capIrqs;
        @(posedge clk_sys);
        rdStb <= 1'b1;
        #1;
        n = int'(count);
        ecpt_pulse_src_inst.drive(1'b1, 30);
        @(posedge clk_sys);
        rdStb <= 1'b0;
        #1;
        check16("capture window", 16'h0001, {15'h0000, capVal >= 16'(n) && capVal <= 16'(n + 5)});
        check16("read window", 16'h0001, {15'h0000, capRd >= 16'(n) && capRd <= 16'(n + 5)});
        checkInt("capture irqs", c0 + 1, capIrqs);
        check16("no overflow", 16'h0000, {15'h0000, ovfFlag});
        finalReport();
    end
endmodule
